// >>> core/itr_timer.sv
// Contract
// - Status bit 1 reads 1 while counting, 0 when stopped.
// - Writing status never changes the running bit.
// - Interrupt asserted only when timeout flag and enable bit 0 both set.
// - Repeat mode keeps counting through zero; otherwise stop at zero, except stopped_at_reset without start/stop control runs on.
// - Reaching zero always reloads the full 32-bit period.
// - Control bit 2 write of 1 starts a stopped counter; else nothing.
// - Control bit 3 write of 1 stops a running counter; else nothing.
// - Without start/stop control, stop bit writes have no effect.
// - Period is 32 bits: low half bits 15..0, high half 31..16.
// - Counter loads the period on any period-half write and at zero.
// - Counter holds zero one cycle before reloading.
// - Period write stops counter unless start/stop control is absent.
// - Fixed period build: period write reloads fixed value, data ignored.
// - Capture write copies whole counter at once into both halves.
// - Capture works running or stopped and never disturbs counting.
// - Clearing timeout flag or enable removes a pending interrupt.
// - Timeout flag sets at zero, clears on a status write of zero.
`timescale 1ns/1ps
module itr_timer #(
    parameter logic [31:0] FIXED_PERIOD = itr_pkg::PERIOD_RESET // Build-time period
) (
    input wire logic ref_clk_i,               // System clock, 10 MHz
    input wire logic arst_n_i,                // Async reset, active low
    input wire itr_pkg::itr_bus_req_t bus_i,  // Register request
    input wire itr_pkg::itr_cfg_t cfg_i,      // Build options, static
    output logic [15:0] rdata_o,              // Read data, one cycle after rd
    output logic irq_o,                       // Interrupt request
    output logic zero_pulse_o                 // Count reached zero, one cycle
);
    import itr_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [31:0] count;
    logic [31:0] period;
    logic [31:0] capture;
    logic running;
    logic timeout_flag;
    logic timeout_irq_enable;
    logic repeat_mode;

    logic wr_status, wr_ctrl, wr_per_lo, wr_per_hi, wr_cap;
    logic at_zero;
    logic [31:0] next_period;
    logic next_timeout_flag;
    logic next_irq_enable;

    // Write strobes
    assign wr_status = bus_i.wr && (bus_i.addr == ADDR_STATUS);
    assign wr_ctrl = bus_i.wr && (bus_i.addr == ADDR_CONTROL);
    assign wr_per_lo = bus_i.wr && (bus_i.addr == ADDR_RELOAD_LO);
    assign wr_per_hi = bus_i.wr && (bus_i.addr == ADDR_RELOAD_HI);
    assign wr_cap = bus_i.wr && (bus_i.addr == ADDR_CAPTURE_LO || bus_i.addr == ADDR_CAPTURE_HI);
    assign at_zero = running && (count == 32'h00000000);

    // Flag and enable after this cycle, so the request never lags the enable
    assign next_timeout_flag = at_zero || (timeout_flag && !(wr_status && !bus_i.wdata[STATUS_TIMEOUT_BIT]));
    assign next_irq_enable = wr_ctrl ? bus_i.wdata[CTRL_IRQ_EN_BIT] : timeout_irq_enable;

    // Period value after this cycle's write
    always_comb begin
        next_period = period;
        if (!cfg_i.writeable_period) begin
            next_period = FIXED_PERIOD;
        end else if (wr_per_lo) begin
            next_period = {period[31:16], bus_i.wdata};
        end else if (wr_per_hi) begin
            next_period = {bus_i.wdata, period[15:0]};
        end
    end

    // Stored period
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period <= FIXED_PERIOD;
        end else begin
            period <= next_period;
        end
    end

    // Down counter
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= FIXED_PERIOD;
        end else if (wr_per_lo || wr_per_hi) begin
            count <= next_period;
        end else if (at_zero) begin
            count <= period;
        end else if (running) begin
            count <= count - 32'h00000001;
        end
    end

    // Run state
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            running <= 1'b0;
        end else if (!cfg_i.start_stop_ctrl) begin
            // Without start/stop control only a start write or a one-shot zero can change state
            if (wr_ctrl && bus_i.wdata[CTRL_START_BIT]) begin
                running <= 1'b1;
            end else if (at_zero && !repeat_mode && !cfg_i.stopped_at_reset) begin
                running <= 1'b0;
            end
        end else if (wr_per_lo || wr_per_hi) begin
            running <= 1'b0;
        end else if (wr_ctrl && bus_i.wdata[CTRL_STOP_BIT]) begin
            running <= 1'b0;
        end else if (wr_ctrl && bus_i.wdata[CTRL_START_BIT]) begin
            running <= 1'b1;
        end else if (at_zero && !repeat_mode) begin
            running <= 1'b0;
        end
    end

    // Timeout flag, set wins over clear
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timeout_flag <= 1'b0;
        end else if (at_zero) begin
            timeout_flag <= 1'b1;
        end else if (wr_status && !bus_i.wdata[STATUS_TIMEOUT_BIT]) begin
            timeout_flag <= 1'b0;
        end
    end

    // Control bits
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timeout_irq_enable <= 1'b0;
            repeat_mode <= 1'b0;
        end else if (wr_ctrl) begin
            timeout_irq_enable <= bus_i.wdata[CTRL_IRQ_EN_BIT];
            repeat_mode <= bus_i.wdata[CTRL_REPEAT_BIT];
        end
    end

    // Snapshot of the live counter
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture <= 32'h00000000;
        end else if (wr_cap) begin
            capture <= count;
        end
    end

    // Interrupt and zero pulse
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
            zero_pulse_o <= 1'b0;
        end else begin
            irq_o <= next_timeout_flag && next_irq_enable;
            zero_pulse_o <= at_zero;
        end
    end

    // Read data, reserved bits read zero
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= READ_ZERO;
        end else if (bus_i.rd) begin
            rdata_o <= READ_ZERO;
            if (bus_i.addr == ADDR_STATUS) begin
                rdata_o[STATUS_TIMEOUT_BIT] <= timeout_flag;
                rdata_o[STATUS_RUNNING_BIT] <= running;
            end else if (bus_i.addr == ADDR_CONTROL) begin
                rdata_o[CTRL_IRQ_EN_BIT] <= timeout_irq_enable;
                rdata_o[CTRL_REPEAT_BIT] <= repeat_mode;
            end else if (bus_i.addr == ADDR_RELOAD_LO) begin
                rdata_o <= period[15:0];
            end else if (bus_i.addr == ADDR_RELOAD_HI) begin
                rdata_o <= period[31:16];
            end else if (bus_i.addr == ADDR_CAPTURE_LO) begin
                rdata_o <= capture[15:0];
            end else if (bus_i.addr == ADDR_CAPTURE_HI) begin
                rdata_o <= capture[31:16];
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_zero_hit;
        at_zero;
    endsequence

    sequence s_reloaded;
        ##1 (count == $past(period));
    endsequence

    a_irq_needs_enable: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        irq_o |-> timeout_irq_enable) else $error("irq without enable");

    a_irq_follows_flag: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (timeout_flag && timeout_irq_enable && !bus_i.wr) |=> irq_o) else $error("irq missing");

    a_zero_reload: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (s_zero_hit and !bus_i.wr) |-> s_reloaded) else $error("no reload at zero");

    a_zero_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        at_zero |=> timeout_flag) else $error("flag not set");

    a_oneshot_stops: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (at_zero && !repeat_mode && cfg_i.start_stop_ctrl && !bus_i.wr) |=> !running) else $error("oneshot ran on");

    a_repeat_runs: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (at_zero && repeat_mode && !bus_i.wr) |=> running) else $error("repeat stopped");

    a_start_runs: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && bus_i.wdata[CTRL_START_BIT] && !bus_i.wdata[CTRL_STOP_BIT]) |=> running)
        else $error("start ignored");

    a_stop_halts: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && bus_i.wdata[CTRL_STOP_BIT] && cfg_i.start_stop_ctrl) |=> !running) else $error("stop ignored");

    a_period_write_loads: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_per_lo || wr_per_hi) |=> (count == period)) else $error("period write no load");

    a_capture_copies: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        wr_cap |=> (capture == $past(count))) else $error("capture wrong");

    a_count_decrements: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (running && count != 32'h00000000 && !bus_i.wr) |=> (count == $past(count) - 32'h00000001))
        else $error("no decrement");

    sequence s_last_tick;
        running && (count == 32'h00000001) && !bus_i.wr;
    endsequence

    // Zero stands one full cycle before the reload
    a_zero_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        s_last_tick |=> s_zero_hit) else $error("zero skipped");

    // Request equals flag and enable
    a_irq_tracks_level: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        irq_o == (timeout_flag && timeout_irq_enable)) else $error("irq level wrong");

    // Acknowledge by flag or enable clear drops the request
    a_irq_drop_ack: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (irq_o && ((wr_status && !bus_i.wdata[STATUS_TIMEOUT_BIT] && !at_zero)
        || (wr_ctrl && !bus_i.wdata[CTRL_IRQ_EN_BIT]))) |=> !irq_o)
        else $error("irq not acknowledged");

    // Status write of zero clears the flag
    a_flag_clear_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_status && !bus_i.wdata[STATUS_TIMEOUT_BIT] && !at_zero) |=> !timeout_flag)
        else $error("flag not cleared");

    // Flag stays up until a status write
    a_flag_holds: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (timeout_flag && !wr_status) |=> timeout_flag) else $error("flag lost");

    // Status write leaves the run state alone
    a_status_keeps_run: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_status && !at_zero) |=> $stable(running)) else $error("status write moved run bit");

    // Period write stops the counter with start/stop control
    a_period_stops: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((wr_per_lo || wr_per_hi) && cfg_i.start_stop_ctrl) |=> !running)
        else $error("period write kept running");

    // Period write keeps it running without start/stop control
    a_period_keeps_run: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((wr_per_lo || wr_per_hi) && !cfg_i.start_stop_ctrl && running && !at_zero) |=> running)
        else $error("period write stopped counter");

    // Fixed period build reloads the build-time value
    a_fixed_reload: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((wr_per_lo || wr_per_hi) && !cfg_i.writeable_period) |=> (count == FIXED_PERIOD))
        else $error("fixed period not loaded");

    // Each period half lands in its own bits
    a_low_half_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_per_lo && cfg_i.writeable_period) |=> (period[15:0] == $past(bus_i.wdata)))
        else $error("low half wrong");

    a_high_half_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_per_hi && cfg_i.writeable_period) |=> (period[31:16] == $past(bus_i.wdata)))
        else $error("high half wrong");

    // Stop bit ignored without start/stop control
    a_stop_ignored: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && !cfg_i.start_stop_ctrl && running && !at_zero) |=> running)
        else $error("stop bit took effect");

    // Stopped counter keeps its value for a later restart
    a_stopped_holds: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (!running && !wr_per_lo && !wr_per_hi) |=> $stable(count)) else $error("stopped count moved");

    // Start while running changes nothing
    a_start_while_running: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_ctrl && running && bus_i.wdata[CTRL_START_BIT] && !bus_i.wdata[CTRL_STOP_BIT] && !at_zero)
        |=> (running && count == $past(count) - 32'h00000001)) else $error("start disturbed counter");

    // Capture leaves a running count undisturbed
    a_capture_running: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (wr_cap && running && !at_zero) |=> (count == $past(count) - 32'h00000001))
        else $error("capture disturbed counter");

    // Status read shows run state and flag, reserved bits zero
    a_read_status: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (bus_i.rd && bus_i.addr == ADDR_STATUS) |=> (rdata_o == {14'h0000, $past(running), $past(timeout_flag)}))
        else $error("status read wrong");

    // Capture high half read back
    a_read_capture: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (bus_i.rd && bus_i.addr == ADDR_CAPTURE_HI) |=> (rdata_o == $past(capture[31:16])))
        else $error("capture read wrong");
endmodule

// >>> core/itr_pkg.sv
package itr_pkg;
    // ************************************************************
    // Register map (word index on the 3-bit address)
    // ************************************************************
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_RELOAD_LO = 3'h2;
    localparam logic [2:0] ADDR_RELOAD_HI = 3'h3;
    localparam logic [2:0] ADDR_CAPTURE_LO = 3'h4;
    localparam logic [2:0] ADDR_CAPTURE_HI = 3'h5;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int STATUS_TIMEOUT_BIT = 0;
    localparam int STATUS_RUNNING_BIT = 1;
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam int CTRL_REPEAT_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_STOP_BIT = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] PERIOD_RESET = 32'h0000FFFF;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } itr_bus_req_t;

    // Build-time options
    typedef struct packed {
        logic writeable_period;
        logic start_stop_ctrl;
        logic stopped_at_reset;
    } itr_cfg_t;
endpackage

// >>> verification/itr_host_model.sv
`timescale 1ns/1ps
// Processor-side model: one register request at a time on the timer bus
module itr_host_model (
    input wire logic ref_clk_i,         // System clock
    input wire logic [15:0] rdata_i,    // Read data from the timer
    output itr_pkg::itr_bus_req_t bus_o // Register request
);
    import itr_pkg::*;
    // Bus idle at time zero
    initial begin
        bus_o = '0;
    end
    // Drop the strobe and scramble the released address and data
    task automatic release_bus();
        @(negedge ref_clk_i);
        bus_o.wr = 1'b0;
        bus_o.rd = 1'b0;
        bus_o.addr = ~bus_o.addr;
        bus_o.wdata = ~bus_o.wdata;
    endtask
    // One write pulse; reserved status/control bits zeroed, stop wins over start
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        logic [15:0] m;
        m = (a < ADDR_RELOAD_LO) ? {12'h000, d[3] ? 4'hB : 4'hF} : 16'hFFFF;
        @(negedge ref_clk_i);
        bus_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & m};
        release_bus();
    endtask
    // One read pulse; data taken once the answering edge has passed
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(negedge ref_clk_i);
        bus_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        release_bus();
        v = rdata_i;
    endtask
endmodule

// >>> verification/interval_timer_regs_tb.sv
`timescale 1ns/1ps
module interval_timer_regs_tb;
    import itr_pkg::*;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    itr_cfg_t cfg = '{1'b1, 1'b1, 1'b0};
    itr_bus_req_t bus;
    logic [15:0] rdata;
    logic irq;
    logic zero_pulse;
    logic [15:0] v1;
    logic [15:0] v2;
    int miscompares = 0;
    int checked = 0;
    int pulses = 0;
    // ************************************************************
    // Clock, pulse count, design and host
    // ************************************************************
    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (zero_pulse === 1'b1) pulses <= pulses + 1;
    end
    itr_timer #(.FIXED_PERIOD(32'h0000000A)) i_itr_timer (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .bus_i(bus),
        .cfg_i(cfg), .rdata_o(rdata), .irq_o(irq), .zero_pulse_o(zero_pulse));
    itr_host_model i_itr_host_model (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .bus_o(bus));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string what);
        logic [15:0] v;
        i_itr_host_model.rd(a, v);
        chk(what, exp, v);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        i_itr_host_model.wr(a, d);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_oneshot();
        int p0;
        rd_chk(ADDR_STATUS, 16'h0000, "status after reset");
        rd_chk(ADDR_RELOAD_LO, 16'h000A, "reload low after reset");
        wr(ADDR_RELOAD_LO, 16'h0005);
        wr(ADDR_RELOAD_HI, 16'h0000);
        rd_chk(ADDR_RELOAD_LO, 16'h0005, "reload low");
        p0 = pulses;
        wr(ADDR_CONTROL, 16'h0005);
        rd_chk(ADDR_STATUS, 16'h0002, "running");
        repeat (20) @(negedge ref_clk_i);
        rd_chk(ADDR_STATUS, 16'h0001, "one-shot stopped, flag");
        chk("irq", 16'h0001, {15'h0000, irq});
        chk("zero pulses", 16'h0001, 16'(pulses - p0));
        wr(ADDR_CAPTURE_LO, 16'hFFFF);
        rd_chk(ADDR_CAPTURE_LO, 16'h0005, "reloaded count low");
        rd_chk(ADDR_CAPTURE_HI, 16'h0000, "reloaded count high");
    endtask
    task automatic t_ack();
        wr(ADDR_STATUS, 16'h0003);
        rd_chk(ADDR_STATUS, 16'h0001, "status kept");
        chk("irq held", 16'h0001, {15'h0000, irq});
        wr(ADDR_STATUS, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0000, "flag cleared");
        chk("irq after flag clear", 16'h0000, {15'h0000, irq});
    endtask
    task automatic t_repeat();
        wr(ADDR_CONTROL, 16'h0006);
        repeat (20) @(negedge ref_clk_i);
        rd_chk(ADDR_STATUS, 16'h0003, "repeat running");
        chk("irq disabled", 16'h0000, {15'h0000, irq});
        wr(ADDR_CONTROL, 16'h0003);
        chk("irq enabled", 16'h0001, {15'h0000, irq});
        wr(ADDR_CONTROL, 16'h0002);
        chk("irq after enable clear", 16'h0000, {15'h0000, irq});
        rd_chk(ADDR_CONTROL, 16'h0002, "control");
        wr(ADDR_CONTROL, 16'h000A);
        rd_chk(ADDR_STATUS, 16'h0001, "stopped");
    endtask
    task automatic t_capture();
        wr(ADDR_RELOAD_LO, 16'h1234);
        wr(ADDR_RELOAD_HI, 16'h0002);
        wr(ADDR_CAPTURE_HI, 16'h0000);
        rd_chk(ADDR_CAPTURE_LO, 16'h1234, "loaded low");
        rd_chk(ADDR_CAPTURE_HI, 16'h0002, "loaded high");
        wr(ADDR_CONTROL, 16'h0004);
        wr(ADDR_CAPTURE_LO, 16'h0000);
        wr(ADDR_CONTROL, 16'h0004);
        rd_chk(ADDR_STATUS, 16'h0003, "started");
        wr(ADDR_CONTROL, 16'h0008);
        wr(ADDR_CAPTURE_LO, 16'h0000);
        i_itr_host_model.rd(ADDR_CAPTURE_LO, v1);
        chk("counted down", 16'h0001, {15'h0000, v1 < 16'h1234});
        wr(ADDR_CAPTURE_HI, 16'h0000);
        rd_chk(ADDR_CAPTURE_LO, v1, "held while stopped");
    endtask
    task automatic t_fixed();
        @(negedge ref_clk_i);
        arst_n_i = 1'b0;
        cfg = '{1'b0, 1'b0, 1'b0};
        repeat (6) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        wr(ADDR_CONTROL, 16'h0006);
        wr(ADDR_RELOAD_LO, 16'h0003);
        wr(ADDR_CAPTURE_LO, 16'h0000);
        i_itr_host_model.rd(ADDR_CAPTURE_LO, v2);
        chk("fixed reload", 16'h0001, {15'h0000, v2 > 16'h0003 && v2 < 16'h000A});
        wr(ADDR_CONTROL, 16'h0008);
        i_itr_host_model.rd(ADDR_STATUS, v2);
        chk("still running", 16'h0002, v2 & 16'h0002);
        repeat (20) @(negedge ref_clk_i);
        rd_chk(ADDR_STATUS, 16'h0001, "one-shot end without control");
    endtask
    task automatic t_watchdog();
        @(negedge ref_clk_i);
        arst_n_i = 1'b0;
        cfg = '{1'b0, 1'b0, 1'b1};
        repeat (6) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        rd_chk(ADDR_STATUS, 16'h0000, "watchdog stopped at reset");
        wr(ADDR_CONTROL, 16'h0004);
        repeat (20) @(negedge ref_clk_i);
        rd_chk(ADDR_STATUS, 16'h0003, "watchdog runs through zero");
        wr(ADDR_RELOAD_HI, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0003, "kick keeps running");
    endtask
    // Reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        t_oneshot();
        t_ack();
        t_repeat();
        t_capture();
        t_fixed();
        t_watchdog();
        stop_test();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule
